// file: rtl/codec_control_register_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "codec_regs_params.svh"

// What this block does
// - any write to the capability word returns every control register to its default.
// - the capability word always reads 0x02A0 and its other bits read zero.
// - capability bit 9 is a constant one flagging a twenty-bit record path.
// - capability bit 7 is a constant one flagging a twenty-bit playback path.
// - capability bit 5 is a constant one flagging bass boost support.
// - the master output level resets to 0x8000, muted with zero attenuation.
// - bits 13 to 8 give left attenuation in 1.5 dB steps, 0 dB down to -94.5 dB.
// - bits 5 to 0 give right attenuation in 1.5 dB steps, 0 dB down to -94.5 dB.
// - the microphone word resets to zero and only bit 6, the 20 dB boost, is writable.
// - reserved and unimplemented bits always read as zero.
// - a read of an unmapped index echoes the index and returns valid zero data.
// - odd indices act as unmapped and never alias onto the even register below.
// - read data goes out in the frame right after the one carrying the request.
module codec_control_register_map
  import codec_regs_pkg::*;
#(
  parameter logic [15:0] VENDOR_WORD_FIRST = 16'h1A2B,  // arbitrary value
  parameter logic [15:0] VENDOR_WORD_SECOND = 16'h3C4D  // arbitrary value
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic link_bit_clock_i,
  input wire logic link_sync_i,
  input wire logic link_data_out_i,
  input wire logic link_reset_n_i,
  input wire logic [15:0] converter_result_i,
  input wire logic [15:0] irq_event_i,
  input wire logic [15:0] clip_event_i,
  output logic link_data_in_o,
  output ctrl_regs_t ctrl_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // power-on and register-reset image of all stored words
  // read-only words are not stored, so they need no entry here
  function automatic ctrl_regs_t defaults();
    ctrl_regs_t r;
    r = '0;
    r.master = `RST_MASTER;
    r.mic = `RST_MIC;
    return r;
  endfunction : defaults

  // read multiplexer; full seven-bit compare keeps odd indices unmapped
  // the converter result is read live rather than stored, so it needs no reset
  function automatic logic [15:0] read_word(input logic [6:0] addr, input ctrl_regs_t r,
                                            input logic [15:0] conv);
    logic [15:0] w;
    w = 16'h0000;  // unmapped and odd indices answer zero
    unique case (addr)
      `OFS_CAPABILITY: w = `CAPABILITY_VALUE;
      `OFS_MASTER: w = r.master;
      `OFS_MIC: w = r.mic;
      `OFS_IRQ_FALL_EN: w = r.irq_fall_en;
      `OFS_IRQ_STATUS: w = r.irq_status;
      `OFS_TOUCH: w = r.touch;
      `OFS_CONV_CTL: w = r.conv_ctl;
      `OFS_CONV_RESULT: w = conv & `MASK_CONV_RESULT;
      `OFS_FEATURE_1: w = r.feature_1;
      `OFS_FEATURE_2: w = r.feature_2;
      `OFS_TEST: w = r.test;
      `OFS_CLIP: w = r.clip;
      `OFS_VENDOR_1: w = VENDOR_WORD_FIRST;
      `OFS_VENDOR_2: w = VENDOR_WORD_SECOND;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // serial bit the device sends at a frame position; only the tag and the
  // first two slots carry anything, every later bit of the frame goes out low
  function automatic logic frame_bit(input logic [7:0] idx, input read_answer_t a);
    logic [15:0] tag;
    logic [19:0] slot1;
    logic [19:0] slot2;
    logic b;
    tag = {1'b1, a.valid, a.valid, 13'h0000};  // device always ready
    slot1 = {1'b0, a.addr, 12'h000};
    slot2 = {a.data, 4'h0};
    b = 1'b0;
    if (idx <= `BIT_TAG_LAST)
    begin
      b = tag[4'(8'd15 - idx)];
    end
    else if (idx <= `BIT_SLOT1_LAST)
    begin
      b = slot1[5'(`BIT_SLOT1_LAST - idx)];
    end
    else if (idx <= `BIT_SLOT2_LAST)
    begin
      b = slot2[5'(`BIT_SLOT2_LAST - idx)];
    end
    return b;
  endfunction : frame_bit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  // first stage feeds only the second; edges are found on the second
  // the two stages cost about two system clocks of latency, which still leaves
  // the answer bit settled well before the host samples it at the falling edge;
  // a link bit clock faster than about a quarter of the system clock breaks this
  logic [3:0] meta_q, meta_d;
  logic [3:0] stab_q, stab_d;
  logic bclk_prev_q, bclk_prev_d;

  always_comb
  begin
    meta_d = {link_reset_n_i, link_data_out_i, link_sync_i, link_bit_clock_i};
    stab_d = meta_q;
    bclk_prev_d = stab_q[0];
  end

  // clearing to zero keeps the link reset asserted for two clocks after power-on
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 4'h0;
      stab_q <= 4'h0;
      bclk_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      bclk_prev_q <= bclk_prev_d;
    end
  end

  // edge strobes last one system clock each
  logic bclk_rise;
  logic bclk_fall;
  logic sync_s;
  logic data_s;
  logic link_rst_n_s;

  assign bclk_rise = stab_q[0] & ~bclk_prev_q;
  assign bclk_fall = ~stab_q[0] & bclk_prev_q;
  assign sync_s = stab_q[1];
  assign data_s = stab_q[2];
  assign link_rst_n_s = stab_q[3];

  // ----------------------------------------------------------------
  // frame engine and register file
  // ----------------------------------------------------------------

  ctrl_regs_t regs_q, regs_d;
  read_answer_t pend_q, pend_d;
  read_answer_t tx_q, tx_d;
  logic [7:0] cnt_q, cnt_d;
  logic sync_prev_q, sync_prev_d;
  logic [19:0] shift_q, shift_d;
  logic [2:0] tag_q, tag_d;
  logic cmd_read_q, cmd_read_d;
  logic [6:0] cmd_addr_q, cmd_addr_d;
  logic sdin_q, sdin_d;

  // decoded every cycle, never stored
  logic [7:0] idx;
  logic [19:0] word;
  logic [15:0] wdata;

  // host data is sampled on falling bit clock, answers change on rising
  // the bit counter only moves on a falling edge and snaps back to zero on a fresh
  // sync rise, so a frame cut short by the host is simply restarted by the next one
  always_comb
  begin
    regs_d = regs_q;
    pend_d = pend_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    sync_prev_d = sync_prev_q;
    shift_d = shift_q;
    tag_d = tag_q;
    cmd_read_d = cmd_read_q;
    cmd_addr_d = cmd_addr_q;
    sdin_d = sdin_q;
    idx = (sync_s & ~sync_prev_q) ? 8'h00 : cnt_q;  // sync rise marks bit zero
    word = {shift_q[18:0], data_s};
    wdata = word[19:4];
    if (bclk_fall)
    begin
      sync_prev_d = sync_s;
      shift_d = word;
      cnt_d = idx + 8'h01;  // wraps after the last frame bit
      if (idx == `BIT_TAG_LAST)
      begin
        tag_d = word[15:13];  // frame, command and data valid
      end
      if (idx == `BIT_SLOT1_LAST)
      begin
        cmd_read_d = word[19];
        cmd_addr_d = word[18:12];
        if (tag_q[2] && tag_q[1] && word[19])
        begin
          // captured now, sent one frame later
          pend_d.valid = 1'b1;
          pend_d.addr = word[18:12];
          pend_d.data = read_word(word[18:12], regs_q, converter_result_i);
        end
      end
      // a write needs all three tag bits, so a read frame never disturbs a word
      if (idx == `BIT_SLOT2_LAST && tag_q == 3'b111 && !cmd_read_q)
      begin
        // unlisted indices, odd ones and read-only words fall through
        unique case (cmd_addr_q)
          `OFS_CAPABILITY: regs_d = defaults();  // any value resets
          `OFS_MASTER: regs_d.master = wdata & `MASK_MASTER;
          `OFS_MIC: regs_d.mic = wdata & `MASK_MIC;
          `OFS_IRQ_FALL_EN: regs_d.irq_fall_en = wdata & `MASK_IRQ;
          `OFS_IRQ_STATUS: regs_d.irq_status = regs_q.irq_status & ~wdata;  // one clears
          `OFS_TOUCH: regs_d.touch = wdata & `MASK_TOUCH;
          `OFS_CONV_CTL: regs_d.conv_ctl = wdata & `MASK_CONV_CTL;
          `OFS_FEATURE_1: regs_d.feature_1 = wdata & `MASK_FEATURE_1;
          `OFS_FEATURE_2: regs_d.feature_2 = wdata & `MASK_FEATURE_2;
          `OFS_TEST: regs_d.test = wdata & `MASK_TEST;
          `OFS_CLIP: regs_d.clip = regs_q.clip & ~wdata;  // one clears
          default: regs_d = regs_q;
        endcase
      end
      if (idx == `BIT_FRAME_LAST)
      begin
        // hand the pending answer to the next frame
        tx_d = pend_q;
        pend_d = '0;
      end
    end
    if (bclk_rise)
    begin
      sdin_d = frame_bit(cnt_q, tx_q);
    end
    // status flags: a fresh event beats a clear in the same cycle
    // so that an event arriving during the host's clear is never lost
    regs_d.irq_status = regs_d.irq_status | (irq_event_i & `MASK_IRQ);
    regs_d.clip = regs_d.clip | (clip_event_i & `MASK_CLIP);
    // link reset pin holds the registers and framing at their defaults
    // it is level sensitive and wins over everything above, events included,
    // so the host sees a clean default image however long it holds the pin
    if (!link_rst_n_s)
    begin
      regs_d = defaults();  // vendor words are constants, so untouched
      pend_d = '0;
      tx_d = '0;
      cnt_d = 8'h00;
      sync_prev_d = 1'b0;
      tag_d = 3'b000;
      sdin_d = 1'b0;
    end
  end

  // registers only; every decision above lives in the combinational process
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      regs_q <= defaults();
      pend_q <= '0;
      tx_q <= '0;
      cnt_q <= 8'h00;
      sync_prev_q <= 1'b0;
      shift_q <= 20'h00000;
      tag_q <= 3'b000;
      cmd_read_q <= 1'b0;
      cmd_addr_q <= 7'h00;
      sdin_q <= 1'b0;
    end
    else
    begin
      regs_q <= regs_d;
      pend_q <= pend_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      sync_prev_q <= sync_prev_d;
      shift_q <= shift_d;
      tag_q <= tag_d;
      cmd_read_q <= cmd_read_d;
      cmd_addr_q <= cmd_addr_d;
      sdin_q <= sdin_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops
  // ----------------------------------------------------------------

  // the whole stored image is exported so the analog side never waits on a read
  // mute, attenuation and boost fields steer the analog paths
  assign ctrl_o = regs_q;
  assign link_data_in_o = sdin_q;

endmodule : codec_control_register_map

`default_nettype wire

// file: rtl/codec_regs_params.svh
`ifndef CODEC_REGS_PARAMS_SVH
`define CODEC_REGS_PARAMS_SVH

// register indices, seven bits as carried in the command slot
`define OFS_CAPABILITY 7'h00
`define OFS_MASTER 7'h02
`define OFS_MIC 7'h0E
`define OFS_IRQ_FALL_EN 7'h60
`define OFS_IRQ_STATUS 7'h62
`define OFS_TOUCH 7'h64
`define OFS_CONV_CTL 7'h66
`define OFS_CONV_RESULT 7'h68
`define OFS_FEATURE_1 7'h6A
`define OFS_FEATURE_2 7'h6C
`define OFS_TEST 7'h6E
`define OFS_CLIP 7'h70
`define OFS_UNUSED 7'h7A
`define OFS_VENDOR_1 7'h7C
`define OFS_VENDOR_2 7'h7E

// fixed read value of the capability word and its three flags
`define CAPABILITY_VALUE 16'h02A0
`define POS_RECORD_20BIT 9
`define POS_PLAYBACK_20BIT 7
`define POS_BASS_BOOST 5

// master output level fields and the microphone boost bit
`define POS_OUTPUT_MUTE 15
`define POS_LEFT_ATT_LSB 8
`define POS_RIGHT_ATT_LSB 0
`define ATT_WIDTH 6
`define POS_MIC_BOOST 6

// reset values
`define RST_MASTER 16'h8000
`define RST_MIC 16'h0000
`define RST_ZERO 16'h0000

// implemented bit masks; every other bit reads as zero
`define MASK_MASTER 16'hBF3F
`define MASK_MIC 16'h0040
`define MASK_IRQ 16'hFBFF
`define MASK_TOUCH 16'h3FFF
`define MASK_CONV_CTL 16'h80BF
`define MASK_CONV_RESULT 16'h83FF
`define MASK_FEATURE_1 16'h7FFD
`define MASK_FEATURE_2 16'hFC37
`define MASK_TEST 16'h007F
`define MASK_CLIP 16'hE000

// frame bit positions, counted from the first tag bit
`define BIT_TAG_LAST 8'h0F
`define BIT_SLOT1_FIRST 8'h10
`define BIT_SLOT1_LAST 8'h23
`define BIT_SLOT2_FIRST 8'h24
`define BIT_SLOT2_LAST 8'h37
`define BIT_FRAME_LAST 8'hFF

`endif

// file: rtl/codec_regs_pkg.sv
package codec_regs_pkg;

  // stored control words, each already masked to its writable bits
  typedef struct packed {
    logic [15:0] master;
    logic [15:0] mic;
    logic [15:0] irq_fall_en;
    logic [15:0] irq_status;
    logic [15:0] touch;
    logic [15:0] conv_ctl;
    logic [15:0] feature_1;
    logic [15:0] feature_2;
    logic [15:0] test;
    logic [15:0] clip;
  } ctrl_regs_t;

  // read answer carried into the following frame
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [15:0] data;
  } read_answer_t;

endpackage : codec_regs_pkg

// file: bench/codec_control_register_map_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// port rules
// ----------
module codec_control_register_map_assertions
  import codec_regs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic link_bit_clock_i,
  input wire logic link_sync_i,
  input wire logic link_data_out_i,
  input wire logic link_reset_n_i,
  input wire logic [15:0] converter_result_i,
  input wire logic [15:0] irq_event_i,
  input wire logic [15:0] clip_event_i,
  input wire logic link_data_in_o,
  input wire ctrl_regs_t ctrl_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // reserved bits must never be stored
  chk_master_reserved: assert property ((ctrl_o.master & 16'h40C0) == 16'h0000)
    else $error("master reserved bit set");
  chk_mic_only_boost: assert property ((ctrl_o.mic & 16'hFFBF) == 16'h0000)
    else $error("mic reserved bit set");
  chk_upper_reserved: assert property (
    {ctrl_o.touch[15:14], ctrl_o.test[15:7], ctrl_o.irq_status[10]} == 12'h000)
    else $error("upper reserved bit set");
  // defaults right after the reset pins
  chk_master_default: assert property (!$past(rst_n_i) |-> ctrl_o.master == 16'h8000)
    else $error("master not muted after reset");
  chk_link_defaults: assert property (!link_reset_n_i [*4] |=> ctrl_o == {16'h8000, 144'h0})
    else $error("link reset left a word");
  chk_link_quiet: assert property (!link_reset_n_i [*4] |=> !link_data_in_o)
    else $error("output active in link reset");
  // output moves only after a bit clock rise, writes land outside the tag slot
  chk_out_after_rise: assert property ($changed(link_data_in_o) |->
    link_bit_clock_i || $past(link_bit_clock_i))
    else $error("output moved off the rise");
  chk_master_sync_low: assert property ($changed(ctrl_o.master) |-> !link_sync_i)
    else $error("master moved in tag slot");
  cov_unmute: cover property ($fell(ctrl_o.master[15]));
  cov_link_reset: cover property ($fell(link_reset_n_i));
  cov_irq: cover property ($rose(ctrl_o.irq_status[0]));
endmodule : codec_control_register_map_assertions
bind codec_control_register_map codec_control_register_map_assertions i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .link_bit_clock_i(link_bit_clock_i),
  .link_sync_i(link_sync_i), .link_data_out_i(link_data_out_i),
  .link_reset_n_i(link_reset_n_i), .converter_result_i(converter_result_i),
  .irq_event_i(irq_event_i), .clip_event_i(clip_event_i),
  .link_data_in_o(link_data_in_o), .ctrl_o(ctrl_o));
`default_nettype wire

// file: bench/ac_link_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// link host model
// ----------------
module ac_link_host_model (
  input wire logic clock_i,
  input wire logic data_in_i,
  output logic bit_clock_o = 1'b0,
  output logic sync_o = 1'b0,
  output logic data_out_o = 1'b0,
  output logic [0:255] rx_o = '0,
  output logic [15:0] frames_o = 16'h0000
);
  // one frame; bit clock runs only inside it, sync covers the tag slot
  task automatic frame(input logic rd, input logic [6:0] idx, input logic [15:0] wd);
    logic [0:255] tx;
    logic [0:255] rx;
    tx = '0;
    rx = '0;
    tx[0:2] = {2'b11, !rd};
    tx[16:23] = {rd, idx};
    tx[36:51] = wd;
    for (int i = 0; i < 256; i++)
    begin
      @(negedge clock_i);
      bit_clock_o <= 1'b1;
      sync_o <= (i < 16);
      data_out_o <= tx[i];
      repeat (4) @(negedge clock_i);
      bit_clock_o <= 1'b0;
      rx[i] = data_in_i;
      repeat (3) @(negedge clock_i);
    end
    // released line shows the inverse so a stale bit is never taken as valid
    data_out_o <= ~tx[255];
    sync_o <= 1'b0;
    rx_o <= rx;
    frames_o <= frames_o + 16'h0001;
  endtask : frame
endmodule : ac_link_host_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// -------------------
// register map bench
// -------------------
module testbench;
  import codec_regs_pkg::*;
  localparam logic [15:0] VEND1 = 16'h5A11; // arbitrary value
  localparam logic [15:0] VEND2 = 16'h6B22; // arbitrary value
  localparam logic [6:0] IDX[6] = '{7'h60, 7'h64, 7'h66, 7'h6A, 7'h6C, 7'h6E};
  localparam logic [15:0] MSK[6] = '{16'hFBFF, 16'h3FFF, 16'h80BF, 16'h7FFD, 16'hFC37, 16'h007F};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lrst_n = 1'b0;
  logic [15:0] conv = 16'h0000;
  logic [15:0] irq_ev = 16'h0000;
  logic [15:0] clip_ev = 16'h0000;
  logic bclk, sync, sdo, sdi;
  ctrl_regs_t ctrl;
  logic [0:255] rx;
  logic [15:0] frames;
  logic [23:0] notes[$];
  int mismatches = 0;
  int compares = 0;
  codec_control_register_map #(.VENDOR_WORD_FIRST(VEND1), .VENDOR_WORD_SECOND(VEND2))
    i_codec_control_register_map (.clock_i(clk), .rst_n_i(rst_n), .link_bit_clock_i(bclk),
    .link_sync_i(sync), .link_data_out_i(sdo), .link_reset_n_i(lrst_n),
    .converter_result_i(conv), .irq_event_i(irq_ev), .clip_event_i(clip_ev),
    .link_data_in_o(sdi), .ctrl_o(ctrl));
  ac_link_host_model i_ac_link_host_model (.clock_i(clk), .data_in_i(sdi), .bit_clock_o(bclk),
    .sync_o(sync), .data_out_o(sdo), .rx_o(rx), .frames_o(frames));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // note what the next frame must answer, then send the command
  task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
    notes.push_back({1'b1, idx, exp});
    i_ac_link_host_model.frame(1'b1, idx, 16'h0000);
  endtask : rd
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    notes.push_back({1'b0, idx, d});
    i_ac_link_host_model.frame(1'b0, idx, d);
  endtask : wr
  // frame n+1 carries the answer to frame n; a late answer shows as a tag mismatch
  initial
  begin : monitor
    logic [23:0] n;
    @(frames);
    forever
    begin
      @(frames);
      @(posedge clk);
      n = notes.pop_front();
      if (n[23])
      begin
        check({13'h0000, rx[0:2]}, 16'h0007);
        check({9'h000, rx[17:23]}, {9'h000, n[22:16]});
        check(rx[36:51], n[15:0]);
      end
      else
      begin
        check({13'h0000, rx[0:2]}, 16'h0004);
      end
    end
  end
  // hang guard
  initial
  begin
    repeat (99000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial
  begin : main
    logic [15:0] v;
    void'($urandom(24));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    lrst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd(7'h00, 16'h02A0);
    rd(7'h02, 16'h8000);
    rd(7'h0E, 16'h0000);
    rd(7'h7C, VEND1);
    // attenuation end codes with reserved bits written high
    wr(7'h02, 16'h7F00);
    rd(7'h02, 16'h3F00);
    check(ctrl.master, 16'h3F00);
    wr(7'h02, 16'hC0FF);
    rd(7'h02, 16'h803F);
    wr(7'h0E, 16'hFFFF);
    rd(7'h0E, 16'h0040);
    // odd and unmapped indices, read-only words
    wr(7'h03, 16'h0000);
    rd(7'h03, 16'h0000);
    rd(7'h02, 16'h803F);
    wr(7'h7C, 16'hFFFF);
    rd(7'h7C, VEND1);
    conv = 16'($urandom());
    wr(7'h68, 16'hFFFF);
    rd(7'h68, conv & 16'h83FF);
    rd(7'h04, 16'h0000);
    rd(7'h7A, 16'h0000);
    // random words into the upper control registers
    foreach (IDX[k])
    begin
      v = 16'($urandom());
      wr(IDX[k], v);
      rd(IDX[k], v & MSK[k]);
    end
    // status set by an event pulse, cleared by writing ones
    v = 16'($urandom());
    irq_ev = v;
    clip_ev = v;
    @(negedge clk);
    irq_ev = 16'h0000;
    clip_ev = 16'h0000;
    check(ctrl.clip, v & 16'hE000);
    rd(7'h62, v & 16'hFBFF);
    wr(7'h62, 16'hFFFF);
    rd(7'h62, 16'h0000);
    // any value to the capability word restores every default
    wr(7'h00, 16'($urandom()));
    rd(7'h00, 16'h02A0);
    rd(7'h02, 16'h8000);
    check(ctrl.master, 16'h8000);
    rd(7'h0E, 16'h0000);
    rd(7'h70, 16'h0000);
    rd(7'h64, 16'h0000);
    rd(7'h7E, VEND2);
    // link reset pin between frames
    wr(7'h0E, 16'h0040);
    lrst_n = 1'b0;
    repeat (6) @(negedge clk);
    lrst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd(7'h0E, 16'h0000);
    wr(7'h0F, 16'hFFFF);
    check(ctrl.mic, 16'h0000);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule : testbench
`default_nettype wire
